// ### hdl/hdmp_port.sv
// Host-bus DMA memory port: decode, write buffer, read-merge-write, parity, processor mapping
// How it works
// - DMA only when address bits 31:27 zero
// - Bits 26:5 pick block, 4:2 longword
// - Processor address minus bits 33:32 gives DMA address
// - Accept 8/16/32-bit singles and all burst timings
// - Narrow writes do read, merge, write
// - Full-width write bursts stream one longword per clock
// - Ignore DMA between 0.5M and 1.0M bytes
// - Check parity on DMA reads, flag errors
// - Everything runs on one bus clock
// - Cycles only after hold request and grant, or from an EISA master
// - Map processor cycles: acknowledge, space, masks, address
`timescale 1ns/10ps
`include "hdmp_params.svh"
module hdmp_port #(
	parameter int BLOCK_BITS = `HDMP_BLOCK_BITS,
	parameter int FIFO_DEPTH = `HDMP_FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_bus_hold_request,
	input wire logic i_bus_hold_grant_n,
	input wire logic i_bus_eisa_master,
	input wire logic i_bus_ads_n,
	input wire logic [31:0] i_io_bus_addr_bits,
	input wire logic i_bus_mem_io,
	input wire logic i_bus_write,
	input wire logic [3:0] i_bus_be_n,
	input wire logic i_bus_blast_n,
	input wire logic [31:0] i_bus_wdata,
	output logic o_bus_rdy_n,
	output logic [31:0] o_bus_rdata,
	output logic o_bus_claim,
	output logic o_parity_error,
	input wire logic i_inject_parity_fault,
	input wire logic [33:0] i_cpu_addr_bits,
	input wire logic [6:0] i_hae,
	output logic [31:0] o_cpu_dma_addr,
	output logic [31:0] o_cpu_hbus_addr,
	output logic o_cpu_hbus_mem,
	output logic o_cpu_hbus_io,
	output logic o_cpu_hbus_iack,
	output logic [3:0] o_cpu_hbus_be_n
);

	localparam int MAW = BLOCK_BITS + 3;
	localparam int FW = 4 + MAW + 32;
	localparam int DW = 36;

	hdmp_pkg::hdmp_bus_state_t bus_state;
	hdmp_pkg::hdmp_drain_state_t drain_state;

	logic addr_hit;
	logic owner_ok;
	logic [MAW-1:0] bus_idx;
	logic [MAW-1:0] first_idx;
	logic [31:0] rdata;
	logic parity_error;

	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [FW-1:0] fifo_in_data;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [FW-1:0] fifo_out_data;
	logic [3:0] head_be_n;
	logic [MAW-1:0] head_idx;
	logic [31:0] head_data;

	logic [3:0] merge_be_n;
	logic [MAW-1:0] merge_idx;
	logic [31:0] merge_data;
	logic [31:0] merged;

	logic mem_en;
	logic mem_we;
	logic [MAW-1:0] mem_addr;
	logic [DW-1:0] mem_wdata;
	logic [DW-1:0] mem_rdata;
	logic rd_issue;
	logic drain_direct;

	// Byte mask from processor length and offset; reserved codes enable nothing
	function automatic logic [3:0] cpu_mask_n(input logic [1:0] len, input logic [1:0] off);
		logic [4:0] ones;
		logic [7:0] shifted;
		ones = 5'((5'h2 << len) - 5'h1);
		shifted = 8'({3'h0, ones} << off);
		if (shifted[7:4] != 4'h0) begin
			cpu_mask_n = `HDMP_BE_NONE;
		end else begin
			cpu_mask_n = ~shifted[3:0];
		end
	endfunction

	// Address decode: local-peripheral bits clear, outside the shadow hole
	assign addr_hit = (i_io_bus_addr_bits[`HDMP_LOCAL_MSB:`HDMP_LOCAL_LSB] == 5'h00) &&
		!((i_io_bus_addr_bits[26:0] >= `HDMP_SHADOW_LO) &&
		(i_io_bus_addr_bits[26:0] <= `HDMP_SHADOW_HI));

	// Only a held-off processor or an EISA master may own the bus here
	assign owner_ok = (i_bus_hold_request && !i_bus_hold_grant_n) || i_bus_eisa_master;

	// Block and longword index; bits above the array's reach are not stored
	assign bus_idx = {i_io_bus_addr_bits[`HDMP_BLOCK_LSB +: BLOCK_BITS],
		i_io_bus_addr_bits[`HDMP_LW_MSB:`HDMP_LW_LSB]};

	// Ready toward the bus master: write when buffer has room, read when data stands
	always_comb begin
		o_bus_rdy_n = 1'b1;
		unique case (bus_state)
			hdmp_pkg::HDMP_BUS_WRITE: o_bus_rdy_n = !fifo_in_ready;
			hdmp_pkg::HDMP_BUS_RDDATA: o_bus_rdy_n = 1'b0;
			hdmp_pkg::HDMP_BUS_IDLE, hdmp_pkg::HDMP_BUS_RDWAIT, hdmp_pkg::HDMP_BUS_RDMEM: o_bus_rdy_n = 1'b1;
		endcase
	end

	assign o_bus_claim = (bus_state != hdmp_pkg::HDMP_BUS_IDLE);
	assign o_bus_rdata = rdata;
	assign o_parity_error = parity_error;

	// Writes enter the buffer on each ready data phase
	assign fifo_in_valid = (bus_state == hdmp_pkg::HDMP_BUS_WRITE);
	assign fifo_in_data = {i_bus_be_n, first_idx, i_bus_wdata};

	// A read starts only once every buffered write has reached memory
	assign rd_issue = (bus_state == hdmp_pkg::HDMP_BUS_RDWAIT) && !fifo_out_valid &&
		(drain_state == hdmp_pkg::HDMP_DRAIN_IDLE);

	// Bus cycle sequencer
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			bus_state <= hdmp_pkg::HDMP_BUS_IDLE;
		end else begin
			unique case (bus_state)
				hdmp_pkg::HDMP_BUS_IDLE: begin
					if (!i_bus_ads_n && i_bus_mem_io && addr_hit && owner_ok) begin
						bus_state <= i_bus_write ? hdmp_pkg::HDMP_BUS_WRITE : hdmp_pkg::HDMP_BUS_RDWAIT;
					end
				end
				hdmp_pkg::HDMP_BUS_WRITE: begin
					if (fifo_in_ready && !i_bus_blast_n) begin
						bus_state <= hdmp_pkg::HDMP_BUS_IDLE;
					end
				end
				hdmp_pkg::HDMP_BUS_RDWAIT: begin
					if (rd_issue) begin
						bus_state <= hdmp_pkg::HDMP_BUS_RDMEM;
					end
				end
				hdmp_pkg::HDMP_BUS_RDMEM: begin
					bus_state <= hdmp_pkg::HDMP_BUS_RDDATA;
				end
				hdmp_pkg::HDMP_BUS_RDDATA: begin
					bus_state <= i_bus_blast_n ? hdmp_pkg::HDMP_BUS_RDWAIT : hdmp_pkg::HDMP_BUS_IDLE;
				end
			endcase
		end
	end

	// Longword index: taken at the address strobe, stepped within the block per burst transfer
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			first_idx <= '0;
		end else if (bus_state == hdmp_pkg::HDMP_BUS_IDLE) begin
			first_idx <= bus_idx;
		end else if ((bus_state == hdmp_pkg::HDMP_BUS_WRITE && fifo_in_ready) ||
			bus_state == hdmp_pkg::HDMP_BUS_RDDATA) begin
			first_idx <= {first_idx[MAW-1:3], 3'(first_idx[2:0] + 3'h1)};
		end
	end

	// Read data register and parity check
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rdata <= 32'h0000_0000;
			parity_error <= 1'b0;
		end else begin
			parity_error <= 1'b0;
			if (bus_state == hdmp_pkg::HDMP_BUS_RDMEM) begin
				rdata <= mem_rdata[31:0];
				parity_error <= (hdmp_pkg::hdmp_parity(mem_rdata[31:0]) != mem_rdata[35:32]);
			end
		end
	end

	// Write buffer between the bus and memory
	hdmp_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_in_valid(fifo_in_valid),
		.o_in_ready(fifo_in_ready),
		.i_in_data(fifo_in_data),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_out_ready),
		.o_out_data(fifo_out_data)
	);

	assign head_be_n = fifo_out_data[FW-1 -: 4];
	assign head_idx = fifo_out_data[32 +: MAW];
	assign head_data = fifo_out_data[31:0];

	// Drain takes one entry whenever it is idle; full longwords go straight in
	assign fifo_out_ready = (drain_state == hdmp_pkg::HDMP_DRAIN_IDLE);
	assign drain_direct = fifo_out_valid && (head_be_n == 4'h0);

	// Drain sequencer: partial entries need one read cycle before the write
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			drain_state <= hdmp_pkg::HDMP_DRAIN_IDLE;
		end else begin
			unique case (drain_state)
				hdmp_pkg::HDMP_DRAIN_IDLE: begin
					if (fifo_out_valid && !drain_direct) begin
						drain_state <= hdmp_pkg::HDMP_DRAIN_MERGE;
					end
				end
				hdmp_pkg::HDMP_DRAIN_MERGE: begin
					drain_state <= hdmp_pkg::HDMP_DRAIN_IDLE;
				end
			endcase
		end
	end

	// Hold the partial entry while its old longword is read
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			merge_be_n <= `HDMP_BE_NONE;
			merge_idx <= '0;
			merge_data <= 32'h0000_0000;
		end else if (drain_state == hdmp_pkg::HDMP_DRAIN_IDLE && fifo_out_valid) begin
			merge_be_n <= head_be_n;
			merge_idx <= head_idx;
			merge_data <= head_data;
		end
	end

	assign merged = hdmp_pkg::hdmp_merge(mem_rdata[31:0], merge_data, merge_be_n);

	// Memory port: drain owns it, a read only runs when the drain is empty
	always_comb begin
		mem_en = 1'b0;
		mem_we = 1'b0;
		mem_addr = first_idx;
		mem_wdata = {hdmp_pkg::hdmp_parity(head_data) ^ {4{i_inject_parity_fault}}, head_data};
		if (drain_state == hdmp_pkg::HDMP_DRAIN_MERGE) begin
			mem_en = 1'b1;
			mem_we = 1'b1;
			mem_addr = merge_idx;
			mem_wdata = {hdmp_pkg::hdmp_parity(merged) ^ {4{i_inject_parity_fault}}, merged};
		end else if (fifo_out_valid) begin
			mem_en = 1'b1;
			mem_we = drain_direct;
			mem_addr = head_idx;
		end else if (rd_issue) begin
			mem_en = 1'b1;
			mem_addr = first_idx;
		end
	end

	hdmp_mem #(
		.AW(MAW),
		.DW(DW)
	) u_mem (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_en(mem_en),
		.i_we(mem_we),
		.i_addr(mem_addr),
		.i_wdata(mem_wdata),
		.o_rdata(mem_rdata)
	);

	// Processor address to bus address, space, acknowledge and byte mask
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_cpu_dma_addr <= 32'h0000_0000;
			o_cpu_hbus_addr <= 32'h0000_0000;
			o_cpu_hbus_mem <= 1'b0;
			o_cpu_hbus_io <= 1'b0;
			o_cpu_hbus_iack <= 1'b0;
			o_cpu_hbus_be_n <= `HDMP_BE_NONE;
		end else begin
			o_cpu_dma_addr <= i_cpu_addr_bits[31:0];
			o_cpu_hbus_addr <= {i_hae, i_cpu_addr_bits[`HDMP_CPU_ROW_MSB:`HDMP_CPU_ROW_LSB], 2'h0};
			o_cpu_hbus_mem <= (i_cpu_addr_bits[`HDMP_CPU_SPACE_MSB:`HDMP_CPU_SPACE_LSB] == `HDMP_CPU_SPACE_MEM);
			o_cpu_hbus_io <= (i_cpu_addr_bits[`HDMP_CPU_SPACE_MSB:`HDMP_CPU_SPACE_LSB] == `HDMP_CPU_SPACE_IO);
			o_cpu_hbus_iack <= (i_cpu_addr_bits[`HDMP_CPU_SPACE_MSB:`HDMP_CPU_SPACE_LSB] == `HDMP_CPU_SPACE_PERIPH) &&
				!i_cpu_addr_bits[`HDMP_CPU_IACK_BIT];
			o_cpu_hbus_be_n <= cpu_mask_n(i_cpu_addr_bits[`HDMP_CPU_LEN_MSB:`HDMP_CPU_LEN_LSB],
				i_cpu_addr_bits[`HDMP_CPU_OFF_MSB:`HDMP_CPU_OFF_LSB]);
		end
	end

endmodule

// ### inc/hdmp_params.svh
// Constants for the host-bus DMA memory port
`ifndef HDMP_PARAMS_SVH
`define HDMP_PARAMS_SVH

// Bus address fields
`define HDMP_LOCAL_MSB 31
`define HDMP_LOCAL_LSB 27
`define HDMP_BLOCK_MSB 26
`define HDMP_BLOCK_LSB 5
`define HDMP_LW_MSB 4
`define HDMP_LW_LSB 2

// Expansion-bus shadow region, byte addresses
`define HDMP_SHADOW_LO 27'h008_0000
`define HDMP_SHADOW_HI 27'h00f_ffff

// Processor address space codes
`define HDMP_CPU_SPACE_MSB 33
`define HDMP_CPU_SPACE_LSB 32
`define HDMP_CPU_SPACE_LOCAL 2'h0
`define HDMP_CPU_SPACE_PERIPH 2'h1
`define HDMP_CPU_SPACE_MEM 2'h2
`define HDMP_CPU_SPACE_IO 2'h3
`define HDMP_CPU_IACK_BIT 31

// Processor length and offset fields for byte masks, row field for the bus address
`define HDMP_CPU_LEN_MSB 6
`define HDMP_CPU_LEN_LSB 5
`define HDMP_CPU_OFF_MSB 8
`define HDMP_CPU_OFF_LSB 7
`define HDMP_CPU_ROW_MSB 31
`define HDMP_CPU_ROW_LSB 9

// Buffer and memory sizes, empty byte mask
`define HDMP_FIFO_DEPTH 8
`define HDMP_BLOCK_BITS 4
`define HDMP_BE_NONE 4'hf

`endif

// ### inc/hdmp_pkg.sv
// Types and shared helpers for the host-bus DMA memory port
package hdmp_pkg;

	typedef enum logic [2:0] {
		HDMP_BUS_IDLE,
		HDMP_BUS_WRITE,
		HDMP_BUS_RDWAIT,
		HDMP_BUS_RDMEM,
		HDMP_BUS_RDDATA
	} hdmp_bus_state_t;

	typedef enum logic {
		HDMP_DRAIN_IDLE,
		HDMP_DRAIN_MERGE
	} hdmp_drain_state_t;

	// Even parity, one bit per byte
	function automatic logic [3:0] hdmp_parity(input logic [31:0] data);
		logic [3:0] p;
		p = 4'h0;
		for (int i = 0; i < 4; i++) begin
			p[i] = ^data[8*i +: 8];
		end
		return p;
	endfunction

	// Keep old bytes where the active-low enable is high
	function automatic logic [31:0] hdmp_merge(input logic [31:0] old_data, input logic [31:0] new_data,
		input logic [3:0] be_n);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[8*i +: 8] = be_n[i] ? old_data[8*i +: 8] : new_data[8*i +: 8];
		end
		return m;
	endfunction

endpackage

// ### hdl/hdmp_fifo.sv
// Parameterised first-in first-out buffer with valid and ready on both sides
`timescale 1ns/10ps
module hdmp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	// Honest full and empty flags from the fill count
	assign o_in_ready = (count != (AW+1)'(DEPTH));
	assign o_out_valid = (count != '0);
	assign o_out_data = store[rd_ptr];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	// Storage array
	always_ff @(posedge i_clk) begin
		if (push) begin
			store[wr_ptr] <= i_in_data;
		end
	end

	// Pointers and count
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end

endmodule

// ### hdl/hdmp_mem.sv
// Single-port host memory array with registered read data
`timescale 1ns/10ps
module hdmp_mem #(
	parameter int AW = 7,
	parameter int DW = 36
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_en,
	input wire logic i_we,
	input wire logic [AW-1:0] i_addr,
	input wire logic [DW-1:0] i_wdata,
	output logic [DW-1:0] o_rdata
);

	logic [DW-1:0] array [2**AW];

	// Write port
	always_ff @(posedge i_clk) begin
		if (i_en && i_we) begin
			array[i_addr] <= i_wdata;
		end
	end

	// Read data comes out of a register one cycle after the request
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else if (i_en && !i_we) begin
			o_rdata <= array[i_addr];
		end
	end

endmodule

// ### test/hdmp_port_checker.sv
// Assertions on the pins of the DMA memory port
`timescale 1ns/10ps
`include "hdmp_params.svh"
module hdmp_port_checker (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_bus_hold_request,
	input wire logic i_bus_hold_grant_n,
	input wire logic i_bus_eisa_master,
	input wire logic i_bus_ads_n,
	input wire logic [31:0] i_io_bus_addr_bits,
	input wire logic i_bus_mem_io,
	input wire logic i_bus_write,
	input wire logic o_bus_rdy_n,
	input wire logic o_bus_claim,
	input wire logic o_parity_error,
	input wire logic [33:0] i_cpu_addr_bits,
	input wire logic [6:0] i_hae,
	input wire logic [31:0] o_cpu_dma_addr,
	input wire logic [31:0] o_cpu_hbus_addr,
	input wire logic o_cpu_hbus_mem,
	input wire logic o_cpu_hbus_iack
);
	logic owner;
	logic shadow;
	logic start;
	logic take;
	logic [33:0] cpu_q;
	logic [6:0] hae_q;
	wire [26:0] low = i_io_bus_addr_bits[26:0];
	// Conditions under which a new cycle must be claimed
	assign owner = (i_bus_hold_request && !i_bus_hold_grant_n) || i_bus_eisa_master;
	assign shadow = low >= `HDMP_SHADOW_LO && low <= `HDMP_SHADOW_HI;
	assign start = !i_bus_ads_n && !o_bus_claim;
	assign take = start && i_bus_mem_io && owner && !shadow && i_io_bus_addr_bits[31:27] == 5'h00;
	// Processor inputs one edge back
	always_ff @(posedge i_clk) begin
		cpu_q <= i_cpu_addr_bits;
		hae_q <= i_hae;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	property p_take; take |=> o_bus_claim; endproperty
	a_take: assert property (p_take) else $error("cycle not claimed");
	property p_local; start && i_io_bus_addr_bits[31:27] != 5'h00 |=> !o_bus_claim; endproperty
	a_local: assert property (p_local) else $error("local address claimed");
	property p_shadow; start && shadow |=> !o_bus_claim; endproperty
	a_shadow: assert property (p_shadow) else $error("shadow range claimed");
	property p_owner; start && !owner |=> !o_bus_claim; endproperty
	a_owner: assert property (p_owner) else $error("cycle claimed without ownership");
	property p_rd; take && !i_bus_write |=> o_bus_rdy_n ##1 o_bus_rdy_n ##[1:60] !o_bus_rdy_n; endproperty
	a_rd: assert property (p_rd) else $error("read answer timing wrong");
	property p_wr; take && i_bus_write |-> ##[1:40] !o_bus_rdy_n; endproperty
	a_wr: assert property (p_wr) else $error("write not answered");
	property p_perr; o_parity_error |-> !o_bus_rdy_n && o_bus_claim; endproperty
	a_perr: assert property (p_perr) else $error("parity flag outside read answer");
	property p_rdy; !o_bus_rdy_n |-> o_bus_claim; endproperty
	a_rdy: assert property (p_rdy) else $error("answer outside owned cycle");
	property p_dma; $past(i_rst_n) |-> o_cpu_dma_addr == cpu_q[31:0]; endproperty
	a_dma: assert property (p_dma) else $error("dma address mapping wrong");
	property p_map; $past(i_rst_n) |-> o_cpu_hbus_addr == {hae_q, cpu_q[31:9], 2'h0}
		&& o_cpu_hbus_mem == (cpu_q[33:32] == 2'h2) && o_cpu_hbus_iack == (cpu_q[33:31] == 3'h2); endproperty
	a_map: assert property (p_map) else $error("processor mapping wrong");
endmodule
bind hdmp_port hdmp_port_checker u_chk (.i_clk, .i_rst_n, .i_bus_hold_request, .i_bus_hold_grant_n,
	.i_bus_eisa_master, .i_bus_ads_n, .i_io_bus_addr_bits, .i_bus_mem_io, .i_bus_write, .o_bus_rdy_n,
	.o_bus_claim, .o_parity_error, .i_cpu_addr_bits, .i_hae, .o_cpu_dma_addr, .o_cpu_hbus_addr,
	.o_cpu_hbus_mem, .o_cpu_hbus_iack);

// ### test/hdmp_master.sv
// Bus owner model: DMA or EISA master running memory cycles
`timescale 1ns/10ps
module hdmp_master (
	input wire logic i_clk,
	input wire logic i_rdy_n,
	input wire logic [31:0] i_rdata,
	input wire logic i_perr,
	output logic o_hold_request,
	output logic o_hold_grant_n,
	output logic o_eisa,
	output logic o_ads_n,
	output logic [31:0] o_addr,
	output logic o_mem_io,
	output logic o_write,
	output logic [3:0] o_be_n,
	output logic o_blast_n,
	output logic [31:0] o_wdata
);
	logic [31:0] rdq [8];
	logic peq [8];
	logic ok;
	logic irq_en = 1'b1;
	logic external_irq_two;
	// Quiet bus owned by the processor side
	initial begin
		{o_hold_request, o_hold_grant_n, o_eisa, o_ads_n, o_mem_io, o_write, o_blast_n} = 7'h2d;
		o_addr = 32'h0;
		o_be_n = 4'hf;
		o_wdata = 32'h0;
	end
	// Peripheral chip turns a flagged read into external interrupt two
	always @(posedge i_clk) external_irq_two <= i_perr && irq_en;
	// Change ownership: request first, grant or EISA ownership an edge later
	task automatic own(input logic req, input logic gnt_n, input logic eisa);
		@(posedge i_clk);
		o_hold_request <= req;
		@(posedge i_clk);
		o_hold_grant_n <= gnt_n;
		o_eisa <= eisa;
	endtask
	// Select memory or I/O space for the cycles that follow
	task automatic space(input logic mem);
		@(posedge i_clk);
		o_mem_io <= mem;
	endtask
	// Single or burst cycle, answer taken at the rising edge
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be, input int n);
		int t;
		ok = 1'b1;
		@(posedge i_clk);
		o_ads_n <= 1'b0;
		o_addr <= a;
		o_write <= w;
		o_wdata <= d;
		o_be_n <= be;
		o_blast_n <= n != 1;
		@(posedge i_clk);
		o_ads_n <= 1'b1;
		o_addr <= ~a;
		for (int k = 0; k < n; k++) begin
			t = 0;
			do begin
				@(posedge i_clk);
				t++;
			end while (i_rdy_n !== 1'b0 && t < 40);
			ok &= i_rdy_n === 1'b0;
			rdq[k] = i_rdata;
			peq[k] = i_perr;
			if (k + 1 < n) begin
				o_wdata <= d + 32'(k + 1);
				o_blast_n <= k + 2 != n;
			end
		end
		// Released lines show the inverse of their last value
		o_wdata <= ~o_wdata;
		o_be_n <= ~be;
		o_blast_n <= 1'b1;
	endtask
endmodule

// ### test/hdmp_port_tb.sv
// Self-checking bench for the DMA memory port
`timescale 1ns/10ps
module hdmp_port_tb;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic inj = 1'b0;
	logic [33:0] cpu = 34'h0;
	logic [6:0] hae = 7'h00;
	logic req, gnt_n, eisa, ads_n, mem_io, wr, blast_n, rdy_n, claim, perr, cmem, cio, ciack;
	logic [31:0] addr, wdata, rdata, dma_a, hb_a;
	logic [3:0] be_n, cbe;
	int n_mismatch = 0;
	int n_tests = 0;
	always #50 i_clk = ~i_clk;
	hdmp_port DUT (.i_clk, .i_rst_n, .i_bus_hold_request(req), .i_bus_hold_grant_n(gnt_n),
		.i_bus_eisa_master(eisa), .i_bus_ads_n(ads_n), .i_io_bus_addr_bits(addr), .i_bus_mem_io(mem_io),
		.i_bus_write(wr), .i_bus_be_n(be_n), .i_bus_blast_n(blast_n), .i_bus_wdata(wdata), .o_bus_rdy_n(rdy_n),
		.o_bus_rdata(rdata), .o_bus_claim(claim), .o_parity_error(perr), .i_inject_parity_fault(inj),
		.i_cpu_addr_bits(cpu), .i_hae(hae), .o_cpu_dma_addr(dma_a), .o_cpu_hbus_addr(hb_a),
		.o_cpu_hbus_mem(cmem), .o_cpu_hbus_io(cio), .o_cpu_hbus_iack(ciack), .o_cpu_hbus_be_n(cbe));
	hdmp_master u_mst (.i_clk, .i_rdy_n(rdy_n), .i_rdata(rdata), .i_perr(perr), .o_hold_request(req),
		.o_hold_grant_n(gnt_n), .o_eisa(eisa), .o_ads_n(ads_n), .o_addr(addr), .o_mem_io(mem_io),
		.o_write(wr), .o_be_n(be_n), .o_blast_n(blast_n), .o_wdata(wdata));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Reset holds the port idle and the outputs at their rest values
	task automatic t_reset;
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		chk({29'h0, rdy_n, claim, perr}, 32'h0000_0004);
		chk(rdata, 32'h0000_0000);
		chk(dma_a, 32'h0000_0000);
		chk({28'h0, cbe}, 32'h0000_000f);
		i_rst_n <= 1'b1;
		$display("t_reset done");
	endtask
	// Run a cycle; an answer missing where one is due ends the run
	task automatic go(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] b, input int n,
		input logic acc);
		u_mst.xfer(w, a, d, b, n);
		chk({31'h0, u_mst.ok}, {31'h0, acc});
		if (acc && u_mst.ok !== 1'b1) end_of_test();
	endtask
	// Read n longwords and compare data and parity flag
	task automatic rd(input logic [31:0] a, input logic [31:0] d, input int n, input logic pe);
		go(1'b0, a, 32'h0, 4'hf, n, 1'b1);
		for (int k = 0; k < n; k++) begin
			chk(u_mst.rdq[k], d + 32'(k));
			chk({31'h0, u_mst.peq[k]}, {31'h0, pe});
		end
	endtask
	// Byte and word writes keep the other bytes
	task automatic t_merge;
		go(1'b1, 32'h0000_0100, 32'h1122_3344, 4'h0, 1, 1'b1);
		go(1'b1, 32'h0000_0100, 32'haabb_ccdd, 4'he, 1, 1'b1);
		go(1'b1, 32'h0000_0100, 32'haabb_ccdd, 4'h3, 1, 1'b1);
		rd(32'h0000_0100, 32'haabb_33dd, 1, 1'b0);
		$display("t_merge done");
	endtask
	// Full burst at speed, partial burst through the read-merge-write drain, burst read
	task automatic t_burst;
		realtime t0;
		t0 = $realtime;
		go(1'b1, 32'h0000_0120, 32'h0000_1000, 4'h0, 8, 1'b1);
		chk(32'(($realtime - t0) <= 1000.0), 32'h1);
		go(1'b1, 32'h0000_0120, 32'h0000_1000, 4'he, 8, 1'b1);
		rd(32'h0000_0120, 32'h0000_1000, 8, 1'b0);
		$display("t_burst done");
	endtask
	// Aliased cycles outside memory or without ownership leave data alone
	task automatic t_refuse;
		go(1'b1, 32'h0800_0100, 32'h0, 4'h0, 1, 1'b0);
		go(1'b1, 32'h0008_0100, 32'h0, 4'h0, 1, 1'b0);
		go(1'b1, 32'h000f_ff00, 32'h0, 4'h0, 1, 1'b0);
		u_mst.space(1'b0);
		go(1'b1, 32'h0000_0100, 32'h0, 4'h0, 1, 1'b0);
		u_mst.space(1'b1);
		u_mst.own(1'b1, 1'b1, 1'b0);
		go(1'b1, 32'h0000_0100, 32'h0, 4'h0, 1, 1'b0);
		u_mst.own(1'b0, 1'b1, 1'b1);
		rd(32'h0000_0100, 32'haabb_33dd, 1, 1'b0);
		u_mst.own(1'b1, 1'b0, 1'b0);
		$display("t_refuse done");
	endtask
	// Corrupted longword flagged on read, clean rewrite not flagged
	task automatic t_parity;
		inj <= 1'b1;
		go(1'b1, 32'h0000_0140, 32'h5a5a_0f0f, 4'h0, 1, 1'b1);
		repeat (3) @(posedge i_clk);
		inj <= 1'b0;
		rd(32'h0000_0140, 32'h5a5a_0f0f, 1, 1'b1);
		@(posedge i_clk);
		chk({31'h0, u_mst.external_irq_two}, 32'h1);
		go(1'b1, 32'h0000_0140, 32'h5a5a_0f0f, 4'h0, 1, 1'b1);
		rd(32'h0000_0140, 32'h5a5a_0f0f, 1, 1'b0);
		@(posedge i_clk);
		chk({31'h0, u_mst.external_irq_two}, 32'h0);
		$display("t_parity done");
	endtask
	// Processor addresses: space, acknowledge, byte masks, bus address
	task automatic t_cpu;
		logic [33:0] c [5] = '{34'h3_0002_3080, 34'h2_0000_0120, 34'h1_0000_0000, 34'h2_0000_0060, 34'h2_0000_0140};
		logic [3:0] m [5] = '{4'hd, 4'h3, 4'he, 4'h0, 4'hf};
		for (int i = 0; i < 5; i++) begin
			cpu <= c[i];
			hae <= 7'(i + 5);
			repeat (2) @(posedge i_clk);
			chk(dma_a, c[i][31:0]);
			chk(hb_a, {7'(i + 5), c[i][31:9], 2'h0});
			chk({28'h0, cbe}, {28'h0, m[i]});
			chk({29'h0, cmem, cio, ciack}, {29'h0, c[i][33:32] == 2'h2, c[i][33:32] == 2'h3, c[i][33:31] == 3'h2});
		end
		$display("t_cpu done");
	endtask
	initial begin
		t_reset();
		u_mst.own(1'b1, 1'b0, 1'b0);
		t_merge();
		t_burst();
		t_refuse();
		t_reset();
		t_parity();
		t_cpu();
		end_of_test();
	end
endmodule
